/* File: core/aqc_consts.svh */
// Constants for the analog quad configuration and sample phase block.
// Included by the package and by the converter end and fabric controller end design files.
`ifndef AQC_CONSTS_SVH
`define AQC_CONSTS_SVH
`define AQC_NUM_QUADS        10
`define AQC_BYTE_VOLT        2'h0
`define AQC_BYTE_CURR        2'h1
`define AQC_BYTE_GATE        2'h2
`define AQC_BYTE_TEMP        2'h3
`define AQC_RST_VOLT         8'h00
`define AQC_RST_CURR         8'h00
`define AQC_RST_GATE         8'h00
`define AQC_RST_TEMP         8'h00
`define AQC_RST_SAMPLE_TIME  8'h03
`define AQC_RST_DIVIDER      8'h01
`define AQC_RST_MODE         4'h4
`define AQC_SCALE_LSB        0
`define AQC_MUX_BIT          3
`define AQC_CURMON_BIT       4
`define AQC_DIRECT_BIT       5
`define AQC_POL_BIT          6
`define AQC_OPAMP_BIT        7
`define AQC_TMON_BIT         0
`define AQC_DRIVE_LSB        2
`define AQC_HIDRV_BIT        7
`define AQC_SAMPLE_BASE      2
`define AQC_CONV_PHASE_CYC   8'h0A
`define AQC_MODE_KEEP_ON_BIT 2
`define AQC_REG_CTRL         4'h0
`define AQC_REG_SAMPLE_TIME  4'h1
`define AQC_REG_DIV          4'h2
`define AQC_REG_CFGADDR      4'h3
`define AQC_REG_CFGDATA      4'h4
`define AQC_REG_STATUS       4'h5
`define AQC_REG_MODE         4'h6
`define AQC_CTRL_START_BIT   0
`define AQC_CTRL_WRITE_BIT   1
`define AQC_CTRL_READ_BIT    2
`endif

/* File: core/aqc_pkg.sv */
// Types shared by both ends of the analog quad configuration link.
// Assumes aqc_consts.svh in the include path.
`include "aqc_consts.svh"
package aqc_pkg;
  typedef enum {AQC_IDLE, AQC_SAMPLE, AQC_CONVERT, AQC_FINISH} aqc_phase_t;
  typedef logic [7:0] aqc_byte_t;
endpackage : aqc_pkg

/* File: core/aqc_link_if.sv */
// Link between the converter end and the fabric controller end.
// Assumes both ends share clk and rstn.
`timescale 1ns/1ns
interface aqc_link_if;
  logic       cfgWrite;
  logic       cfgRead;
  logic [3:0] cfgQuad;
  logic [1:0] cfgByte;
  logic [7:0] cfgWdata;
  logic [7:0] cfgRdata;
  logic       convStart;
  logic [7:0] sampleTimeCount;
  logic [7:0] converterClockDivider;
  logic [3:0] convMode;
  logic       busy;
  logic       sample;
  logic       powered;
  // The converter end answers configuration reads and reports the sample phase.
  modport device (input cfgWrite, cfgRead, cfgQuad, cfgByte, cfgWdata, convStart, sampleTimeCount,
                  converterClockDivider, convMode, output cfgRdata, busy, sample, powered);
  // The fabric controller issues configuration and conversion requests.
  modport ctrl (output cfgWrite, cfgRead, cfgQuad, cfgByte, cfgWdata, convStart, sampleTimeCount,
                converterClockDivider, convMode, input cfgRdata, busy, sample, powered);
endinterface : aqc_link_if

/* File: core/aqc_clock_divider.sv */
// Converter clock enable generator: one tick every divider+1 system cycles.
// Assumes a synchronous active-low reset.
`timescale 1ns/1ns
module aqc_clock_divider
  import aqc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] converterClockDivider,
  output logic            tick
);
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic       tick_nxt;
  logic       tick_r;

  // Count down to zero, then reload; the tick is registered to keep it clean.
  always_comb begin
    tick_nxt  = (count_r == 8'h00);
    count_nxt = tick_nxt ? converterClockDivider : count_r - 8'h01;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_r <= 8'h00;
      tick_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : aqc_clock_divider

/* File: core/aqc_device.sv */
// Converter end: quad configuration bytes, readback and sample phase sequencing.
// Assumes the fabric controller drives the link synchronously to clk.
`timescale 1ns/1ns
`include "aqc_consts.svh"
module aqc_device
  import aqc_pkg::*;
#(
  parameter int NUM_QUADS = `AQC_NUM_QUADS
)
(
  input  wire logic              clk,
  input  wire logic              rstn,
  aqc_link_if.device             link,
  output logic [3*NUM_QUADS-1:0] voltagePadScale,
  output logic [NUM_QUADS-1:0]   voltagePadMuxSel,
  output logic [NUM_QUADS-1:0]   currentMonitorOn,
  output logic [NUM_QUADS-1:0]   voltagePadDirectOn,
  output logic [NUM_QUADS-1:0]   voltagePadNegative,
  output logic [NUM_QUADS-1:0]   voltagePadOpampOn,
  output logic [3*NUM_QUADS-1:0] currentPadScale,
  output logic [NUM_QUADS-1:0]   currentPadMuxSel,
  output logic [NUM_QUADS-1:0]   currentPadDirectOn,
  output logic [NUM_QUADS-1:0]   currentPadNegative,
  output logic [NUM_QUADS-1:0]   currentPadOpampOn,
  output logic [2*NUM_QUADS-1:0] gateDriveCurrent,
  output logic [NUM_QUADS-1:0]   gatePadNegative,
  output logic [NUM_QUADS-1:0]   gateHighDrive,
  output logic [3*NUM_QUADS-1:0] temperaturePadScale,
  output logic [NUM_QUADS-1:0]   temperaturePadMuxSel,
  output logic [NUM_QUADS-1:0]   temperaturePadDirectOn,
  output logic [NUM_QUADS-1:0]   temperaturePadOpampOn,
  output logic                   chipTempMonitorOn,
  output logic                   convDone
);
  // Four configuration bytes per quad, kept in one small array.
  aqc_byte_t  cfg_r [NUM_QUADS][4];
  aqc_byte_t  cfg_nxt [NUM_QUADS][4];
  aqc_byte_t  rdata_r;
  aqc_byte_t  rdata_nxt;
  aqc_phase_t phase_r;
  aqc_phase_t phase_nxt;
  // Ticks left in the current phase; nine bits hold the largest sample count.
  logic [8:0] count_r;
  logic [8:0] count_nxt;
  logic       powered_r;
  logic       powered_nxt;
  logic       done_r;
  logic       done_nxt;
  logic       tick;

  // Converter clock enable derived from the system clock.
  // The divider runs free, so the first tick of a sample phase may come early.
  aqc_clock_divider u_div (
    .clk                   (clk),
    .rstn                  (rstn),
    .converterClockDivider (link.converterClockDivider),
    .tick                  (tick)
  );

  // Reset value of each byte slot.
  function automatic aqc_byte_t cfgDefault(input logic [1:0] sel);
    case (sel)
      `AQC_BYTE_VOLT: cfgDefault = `AQC_RST_VOLT;
      `AQC_BYTE_CURR: cfgDefault = `AQC_RST_CURR;
      `AQC_BYTE_GATE: cfgDefault = `AQC_RST_GATE;
      default:        cfgDefault = `AQC_RST_TEMP;
    endcase
  endfunction : cfgDefault

  // Writes land in the addressed byte; quads beyond the last are ignored.
  // A read of an absent quad returns zero rather than stale data.
  always_comb begin
    cfg_nxt   = cfg_r;
    rdata_nxt = 8'h00;
    if (link.cfgWrite && (32'(link.cfgQuad) < NUM_QUADS)) begin
      cfg_nxt[link.cfgQuad][link.cfgByte] = link.cfgWdata;
    end
    if (link.cfgRead && (32'(link.cfgQuad) < NUM_QUADS)) begin
      rdata_nxt = cfg_r[link.cfgQuad][link.cfgByte];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      // Every byte goes back to its default on reset, whatever was written before.
      for (int q = 0; q < NUM_QUADS; q++) begin
        for (int b = 0; b < 4; b++) begin
          cfg_r[q][b] <= cfgDefault(2'(b));
        end
      end
      rdata_r <= 8'h00;
    end else begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Decode of the four bytes onto the analog controls.
  always_comb begin
    chipTempMonitorOn = 1'b1;
    for (int q = 0; q < NUM_QUADS; q++) begin
      voltagePadScale[3*q +: 3]   = cfg_r[q][0][`AQC_SCALE_LSB +: 3];
      voltagePadMuxSel[q]         = cfg_r[q][0][`AQC_MUX_BIT];
      currentMonitorOn[q]         = cfg_r[q][0][`AQC_CURMON_BIT];
      voltagePadDirectOn[q]       = cfg_r[q][0][`AQC_DIRECT_BIT];
      voltagePadNegative[q]       = cfg_r[q][0][`AQC_POL_BIT];
      voltagePadOpampOn[q]        = cfg_r[q][0][`AQC_OPAMP_BIT];
      currentPadScale[3*q +: 3]   = cfg_r[q][1][`AQC_SCALE_LSB +: 3];
      currentPadMuxSel[q]         = cfg_r[q][1][`AQC_MUX_BIT];
      currentPadDirectOn[q]       = cfg_r[q][1][`AQC_DIRECT_BIT];
      currentPadNegative[q]       = cfg_r[q][1][`AQC_POL_BIT];
      currentPadOpampOn[q]        = cfg_r[q][1][`AQC_OPAMP_BIT];
      gateDriveCurrent[2*q +: 2]  = cfg_r[q][2][`AQC_DRIVE_LSB +: 2];
      gatePadNegative[q]          = cfg_r[q][2][`AQC_POL_BIT];
      gateHighDrive[q]            = cfg_r[q][2][`AQC_HIDRV_BIT];
      temperaturePadScale[3*q +: 3] = cfg_r[q][3][`AQC_SCALE_LSB +: 3];
      temperaturePadMuxSel[q]     = cfg_r[q][3][`AQC_MUX_BIT];
      temperaturePadDirectOn[q]   = cfg_r[q][3][`AQC_DIRECT_BIT];
      temperaturePadOpampOn[q]    = cfg_r[q][3][`AQC_OPAMP_BIT];
      // The monitor only works when every quad has its enable set.
      chipTempMonitorOn = chipTempMonitorOn & cfg_r[q][2][`AQC_TMON_BIT];
    end
  end

  // Conversion sequencer; counts run on converter clock ticks only.
  always_comb begin
    phase_nxt   = phase_r;
    count_nxt   = count_r;
    powered_nxt = powered_r;
    done_nxt    = 1'b0;
    case (phase_r)
      AQC_IDLE: begin
        // A start while busy never reaches this branch, so a running conversion is safe.
        if (link.convStart) begin
          phase_nxt   = AQC_SAMPLE;
          powered_nxt = 1'b1;
          // Sample spans 2 + count converter periods.
          count_nxt   = 9'(`AQC_SAMPLE_BASE) + {1'b0, link.sampleTimeCount} - 9'h001;
        end
      end
      AQC_SAMPLE: begin
        if (tick) begin
          if (count_r == 9'h000) begin
            phase_nxt = AQC_CONVERT;
            count_nxt = {1'b0, `AQC_CONV_PHASE_CYC} - 9'h001;
          end else begin
            count_nxt = count_r - 9'h001;
          end
        end
      end
      AQC_CONVERT: begin
        // The convert length is fixed; only the sample phase follows the input.
        if (tick) begin
          if (count_r == 9'h000) begin
            phase_nxt = AQC_FINISH;
          end else begin
            count_nxt = count_r - 9'h001;
          end
        end
      end
      AQC_FINISH: begin
        // Keeping power on saves the wake-up; dropping it costs no accuracy.
        if (tick) begin
          phase_nxt   = AQC_IDLE;
          done_nxt    = 1'b1;
          powered_nxt = link.convMode[`AQC_MODE_KEEP_ON_BIT];
        end
      end
      default: phase_nxt = AQC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_r   <= AQC_IDLE;
      count_r   <= 9'h000;
      powered_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      count_r   <= count_nxt;
      powered_r <= powered_nxt;
      done_r    <= done_nxt;
    end
  end

  // Busy covers every phase but idle; sample only the first.
  // Both come from the phase register, so they rise in the same cycle.
  assign link.busy     = (phase_r != AQC_IDLE);
  assign link.sample   = (phase_r == AQC_SAMPLE);
  assign link.powered  = powered_r;
  assign link.cfgRdata = rdata_r;
  assign convDone      = done_r;
endmodule : aqc_device

/* File: core/aqc_ctrl.sv */
// Fabric controller end: software registers steering configuration and conversion.
// Assumes a plain one-cycle strobe register port on the user side.
`timescale 1ns/1ns
`include "aqc_consts.svh"
module aqc_ctrl
  import aqc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  aqc_link_if.ctrl        link,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic [7:0]      regRdata
);
  logic [7:0] sampleTime_r, sampleTime_nxt;
  logic [7:0] div_r, div_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [7:0] rback_r, rback_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] pulse_r, pulse_nxt;
  logic       rdPend_r, rdPend_nxt;

  // Defaults follow the 66 MHz 10-bit recommendation.
  always_comb begin
    sampleTime_nxt = sampleTime_r;
    div_nxt    = div_r;
    mode_nxt   = mode_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    pulse_nxt  = 3'h0;
    rdPend_nxt = pulse_r[`AQC_CTRL_READ_BIT];
    rback_nxt  = rdPend_r ? link.cfgRdata : rback_r;
    rdata_nxt  = 8'h00;
    if (regWrite) begin
      case (regAddr)
        `AQC_REG_CTRL:    pulse_nxt = regWdata[2:0];
        `AQC_REG_SAMPLE_TIME: sampleTime_nxt = regWdata;
        `AQC_REG_DIV:     div_nxt   = regWdata;
        `AQC_REG_CFGADDR: addr_nxt  = regWdata[5:0];
        `AQC_REG_CFGDATA: wdata_nxt = regWdata;
        `AQC_REG_MODE:    mode_nxt  = regWdata[3:0];
        default:          ;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `AQC_REG_SAMPLE_TIME: rdata_nxt = sampleTime_r;
        `AQC_REG_DIV:     rdata_nxt = div_r;
        `AQC_REG_CFGADDR: rdata_nxt = {2'h0, addr_r};
        `AQC_REG_CFGDATA: rdata_nxt = rback_r;
        `AQC_REG_STATUS:  rdata_nxt = {5'h00, link.powered, link.sample, link.busy};
        `AQC_REG_MODE:    rdata_nxt = {4'h0, mode_r};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sampleTime_r <= `AQC_RST_SAMPLE_TIME;
      div_r    <= `AQC_RST_DIVIDER;
      mode_r   <= `AQC_RST_MODE;
      addr_r   <= 6'h00;
      wdata_r  <= 8'h00;
      rback_r  <= 8'h00;
      rdata_r  <= 8'h00;
      pulse_r  <= 3'h0;
      rdPend_r <= 1'b0;
    end else begin
      sampleTime_r <= sampleTime_nxt;
      div_r    <= div_nxt;
      mode_r   <= mode_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      rback_r  <= rback_nxt;
      rdata_r  <= rdata_nxt;
      pulse_r  <= pulse_nxt;
      rdPend_r <= rdPend_nxt;
    end
  end

  // Address byte: quad in bits 5:2, byte select in bits 1:0.
  assign link.cfgQuad               = addr_r[5:2];
  assign link.cfgByte               = addr_r[1:0];
  assign link.cfgWdata              = wdata_r;
  assign link.cfgWrite              = pulse_r[`AQC_CTRL_WRITE_BIT];
  assign link.cfgRead               = pulse_r[`AQC_CTRL_READ_BIT];
  // A start while busy is dropped so the running conversion is not disturbed.
  assign link.convStart             = pulse_r[`AQC_CTRL_START_BIT] & ~link.busy;
  assign link.sampleTimeCount       = sampleTime_r;
  assign link.converterClockDivider = div_r;
  assign link.convMode              = mode_r;
  assign regRdata                   = rdata_r;
endmodule : aqc_ctrl

/* File: test/aqc_props.sv */
// Concurrent checks on the link between the converter end and the controller end.
// Assumes one clock domain, clk, with a synchronous active-low rstn.
`timescale 1ns/1ns
module aqc_props (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       cfgWrite,
  input wire logic       cfgRead,
  input wire logic       convStart,
  input wire logic [7:0] sampleTimeCount,
  input wire logic [7:0] converterClockDivider,
  input wire logic [3:0] convMode,
  input wire logic       busy,
  input wire logic       sample,
  input wire logic       powered
);
  logic [15:0] sampCnt_r;
  logic [15:0] convCnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Phase lengths are counted here; the first tick phase is free, so the bounds allow one tick of slack.
  always_ff @(posedge clk) begin
    sampCnt_r <= (rstn && sample) ? sampCnt_r + 16'h0001 : 16'h0000;
    convCnt_r <= (rstn && busy && !sample) ? convCnt_r + 16'h0001 : 16'h0000;
  end
  chk_start_enters_sample: assert property (convStart |=> busy && sample) else $error("no sample phase");
  chk_start_when_idle: assert property (convStart |-> !busy) else $error("start while busy");
  chk_sample_in_busy: assert property (sample |-> busy) else $error("sample without busy");
  chk_convert_follows: assert property ($fell(sample) |-> busy) else $error("no convert phase");
  chk_sample_length: assert property ($fell(sample) |-> sampCnt_r >= (1 + sampleTimeCount) *
    (converterClockDivider + 1) && sampCnt_r <= (2 + sampleTimeCount) * (converterClockDivider + 1) + 1)
    else $error("sample length wrong");
  chk_convert_length: assert property ($fell(busy) |-> convCnt_r >= 10 * (converterClockDivider + 1) &&
    convCnt_r <= 12 * (converterClockDivider + 1) + 1) else $error("convert length wrong");
  chk_power_while_busy: assert property (busy |-> powered) else $error("unpowered while busy");
  chk_power_after_done: assert property ($fell(busy) |-> ##[0:1] powered == convMode[2])
    else $error("power state after conversion wrong");
  chk_reset_idle: assert property ($rose(rstn) |-> !busy && !sample && !powered) else $error("not idle");
  chk_cfg_pulse: assert property (cfgWrite || cfgRead |=> !cfgWrite && !cfgRead) else $error("long strobe");
  // Main scenarios.
  cover property (convStart && sampleTimeCount == 8'h00);
  cover property ($fell(busy) && !convMode[2]);
  cover property (cfgWrite);
  cover property (cfgRead);
endmodule : aqc_props

/* File: test/test_analog_quad_config_and_sample_phase.sv */
// Self-checking bench joining both ends over the link interface, with a reference model of the bytes.
// Assumes the design files under core/ and the checker are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_analog_quad_config_and_sample_phase;
  logic        clk, rstn, regWrite, regRead, tempOn, convDone;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata, rd8, exp8;
  logic [7:0]  expQ [$];
  logic [29:0] vScale, cScale, tScale;
  logic [19:0] gDrv;
  logic [9:0]  vMux, curMon, vDir, vNeg, vOp, cMux, cDir, cNeg, cOp, gNeg, gHi, tMux, tDir, tOp;
  logic [7:0]  m [10][4] = '{default: 8'h00};
  int          fail_count, compares, seed, n, dn, k;
  aqc_link_if link ();
  aqc_ctrl aqc_ctrl_i (.clk(clk), .rstn(rstn), .link(link), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  aqc_device aqc_device_i (.clk(clk), .rstn(rstn), .link(link), .voltagePadScale(vScale), .voltagePadMuxSel(vMux),
    .currentMonitorOn(curMon), .voltagePadDirectOn(vDir), .voltagePadNegative(vNeg), .voltagePadOpampOn(vOp),
    .currentPadScale(cScale), .currentPadMuxSel(cMux), .currentPadDirectOn(cDir), .currentPadNegative(cNeg),
    .currentPadOpampOn(cOp), .gateDriveCurrent(gDrv), .gatePadNegative(gNeg), .gateHighDrive(gHi),
    .temperaturePadScale(tScale), .temperaturePadMuxSel(tMux), .temperaturePadDirectOn(tDir),
    .temperaturePadOpampOn(tOp), .chipTempMonitorOn(tempOn), .convDone(convDone));
  aqc_props aqc_props_i (.clk(clk), .rstn(rstn), .cfgWrite(link.cfgWrite), .cfgRead(link.cfgRead),
    .convStart(link.convStart), .sampleTimeCount(link.sampleTimeCount),
    .converterClockDivider(link.converterClockDivider), .convMode(link.convMode), .busy(link.busy),
    .sample(link.sample), .powered(link.powered));
  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Sample cycles and completion pulses are counted away from the edge, so no race with the design.
  always @(negedge clk) begin
    if (link.sample === 1'b1) n++;
    if (convDone === 1'b1) dn++;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask : rd
  // One configuration write or readback through the controller; the model only holds the ten real quads.
  task automatic cfg(input int q, input int b, input logic [7:0] d, input bit w);
    wr(4'h3, {2'h0, q[3:0], b[1:0]});
    if (w) begin
      wr(4'h4, d);
      wr(4'h0, 8'h02);
      if (q < 10) m[q][b] = d;
      repeat (3) @(posedge clk);
    end else begin
      expQ.push_back((q < 10) ? m[q][b] : 8'h00);
      wr(4'h0, 8'h04);
      repeat (4) @(posedge clk);
      rd(4'h4, rd8);
      exp8 = expQ.pop_front();
      `CHK(rd8, exp8);
    end
  endtask : cfg
  // Every decoded field against the model bytes.
  task automatic decode;
    bit allOn;
    allOn = 1'b1;
    @(negedge clk);
    for (int q = 0; q < 10; q++) begin
      `CHK({vOp[q], vNeg[q], vDir[q], curMon[q], vMux[q], vScale[3*q+:3]}, m[q][0]);
      `CHK({cOp[q], cNeg[q], cDir[q], cMux[q], cScale[3*q+:3]}, {m[q][1][7:5], m[q][1][3:0]});
      `CHK({gHi[q], gNeg[q], gDrv[2*q+:2]}, {m[q][2][7:6], m[q][2][3:2]});
      `CHK({tOp[q], tDir[q], tMux[q], tScale[3*q+:3]}, {m[q][3][7], m[q][3][5], m[q][3][3:0]});
      allOn &= m[q][2][0];
    end
    `CHK(tempOn, allOn);
  endtask : decode
  // A second start lands while busy and must be dropped, so exactly one completion is expected.
  task automatic conv(input int s, input int dv, input logic [3:0] md);
    wr(4'h1, s[7:0]);
    wr(4'h2, dv[7:0]);
    wr(4'h6, {4'h0, md});
    n = 0;
    dn = 0;
    wr(4'h0, 8'h01);
    k = 0;
    while (link.busy !== 1'b1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    wr(4'h0, 8'h01);
    while (link.busy === 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    repeat (20) @(negedge clk);
    `CHK(n >= (1 + s) * (dv + 1) && n <= (2 + s) * (dv + 1) + 1, 1'b1);
    `CHK(dn, 1);
    rd(4'h5, rd8);
    `CHK(rd8, {5'h00, md[2], 2'h0});
  endtask : conv
  task automatic summarize;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  // A hang counts as a mismatch; the whole run needs well under 20000 cycles.
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
  // Main sequence: reset values, unmapped access, bytes, decode, temperature enable, conversions.
  initial begin
    rstn = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    seed = 32'hB02FEFE6;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h1, rd8);
    `CHK(rd8, 8'h03);
    rd(4'h2, rd8);
    `CHK(rd8, 8'h01);
    rd(4'h6, rd8);
    `CHK(rd8, 8'h04);
    wr(4'hF, 8'hFF);
    rd(4'hF, rd8);
    `CHK(rd8, 8'h00);
    for (int q = 0; q < 10; q++) for (int b = 0; b < 4; b++) cfg(q, b, 8'h00, 1'b0);
    decode();
    for (int q = 0; q < 12; q++) for (int b = 0; b < 4; b++) cfg(q, b, 8'($random(seed)), 1'b1);
    for (int q = 0; q < 12; q++) for (int b = 0; b < 4; b++) cfg(q, b, 8'h00, 1'b0);
    decode();
    cfg(9, 2, 8'h00, 1'b1);
    for (int q = 0; q < 10; q++) begin
      cfg(q, 2, 8'($random(seed)) | 8'h01, 1'b1);
      `CHK(tempOn, q == 9);
    end
    decode();
    for (int i = 0; i < 3; i++) conv(i == 2 ? ($random(seed) & 15) : 3 * i, i, i == 0 ? 4'h0 : 4'h4);
    // A second reset in mid-run must bring every byte and the sample time register back to its default.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    m = '{default: 8'h00};
    rd(4'h1, rd8);
    `CHK(rd8, 8'h03);
    decode();
    summarize();
  end
endmodule : test_analog_quad_config_and_sample_phase
